// *** verilog/pcseq_top.sv ***
// Behaviour
// - Address is 13-bit counter plus segment bit
// - Counter bits 12:11 select one of four pages
// - Segment bit set by system entry, or loaded from pointer or stack slot
// - Direct jump never changes the segment
// - Indirect jump loads full address from pointer
// - Indirect call loads full address from pointer
// - Direct call targets page 0, current segment
// - Table read fetches pointer word into buffer
// - One instruction per 16-bit program word
// - Segment 1 starts at 2000H
// - System entry goes to segment 1 page 0
// - Entry operand: 3 block bits, 4 word bits
// - Returns reload address from selected stack slot
// - Other instructions increment, segment unchanged
// - Interrupt clears segment, loads source vector
// - Every reset source clears address to zero
// - External vectors 00CH then 00BH down 007H
// - Internal vectors 006H down to 001H
// - Increment wraps within segment, no carry out
// - Call or interrupt decrements index, then stores
// - Stack slot saves and restores segment bit
`include "pcseq_consts.svh"

module pcseq_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SYS_RESET,
  input wire logic INSTR_VALID,
  input wire logic [3:0] INSTR_OP,
  input wire logic [`PCSEQ_PC_W-1:0] INSTR_OPERAND,
  input wire logic [`PCSEQ_ADDR_W-1:0] ADDR_PTR,
  input wire logic [`PCSEQ_WORD_W-1:0] ROM_DATA,
  input wire logic IRQ_ACCEPT,
  input wire logic [`PCSEQ_IRQ_N-1:0] IRQ_PENDING,
  output logic [`PCSEQ_ADDR_W-1:0] ROM_ADDR,
  output logic [`PCSEQ_WORD_W-1:0] DATA_BUF,
  output logic [3:0] STACK_INDEX,
  output logic IRQ_TAKEN,
  output logic BUSY
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pcseq_pkg::pcseq_state_e state;
    pcseq_pkg::pcseq_addr_s addr;
    pcseq_pkg::pcseq_addr_s ret;
    logic [`PCSEQ_WORD_W-1:0] data_buffer;
  } pcseq_top_s;

  pcseq_top_s q, d;
  pcseq_pkg::pcseq_op_e op;
  pcseq_pkg::pcseq_addr_s incr;
  pcseq_pkg::pcseq_addr_s ptr;
  logic running;
  logic take_irq;
  logic exec;

  pcseq_link_if lk ();

  // ----------------------------------------------------------------
  // Return stack and vector priority
  // ----------------------------------------------------------------
  pcseq_stack #(
    .DEPTH(`PCSEQ_STACK_DEPTH)
  ) u_stack (
    .clk(CLK),
    .rst_n(RST_N),
    .lk(lk.stk)
  );

  pcseq_vec u_vec (
    .lk(lk.vec)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign op = pcseq_pkg::pcseq_op_e'(INSTR_OP);
  assign ptr = pcseq_pkg::pcseq_addr_s'(ADDR_PTR);
  assign running = (q.state == pcseq_pkg::ST_RUN) && !SYS_RESET;
  // Interrupt wins over the instruction presented in the same cycle
  assign take_irq = running && IRQ_ACCEPT && lk.irq_any;
  assign exec = running && !take_irq && INSTR_VALID;
  assign lk.irq_pending = IRQ_PENDING;

  // Segment bit never joins the carry chain
  assign incr.segment_bit = q.addr.segment_bit;
  assign incr.pc = q.addr.pc + `PCSEQ_PC_ONE;

  // ----------------------------------------------------------------
  // Next address
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    lk.push = 1'b0;
    lk.pop = 1'b0;
    lk.clear = 1'b0;
    lk.push_data = q.addr;
    if (SYS_RESET) begin
      d.state = pcseq_pkg::ST_RUN;
      d.addr.segment_bit = `PCSEQ_SEG_USER;
      d.addr.pc = `PCSEQ_PC_RST;
      lk.clear = 1'b1;
    end else begin
      case (q.state)
        pcseq_pkg::ST_TABLE: begin
          // Word at the pointer is on ROM_DATA now
          d.data_buffer = ROM_DATA;
          d.addr = q.ret;
          d.state = pcseq_pkg::ST_RUN;
        end
        default: begin
          if (take_irq) begin
            lk.push = 1'b1;
            lk.push_data = q.addr;
            d.addr.segment_bit = `PCSEQ_SEG_USER;
            d.addr.pc = pcseq_pkg::pcseq_pc_t'(lk.vector);
          end else if (exec) begin
            case (op)
              pcseq_pkg::OP_JUMP_DIRECT: begin
                d.addr.pc = INSTR_OPERAND;
              end
              pcseq_pkg::OP_JUMP_INDIRECT: begin
                d.addr = ptr;
              end
              pcseq_pkg::OP_CALL_DIRECT: begin
                lk.push = 1'b1;
                lk.push_data = incr;
                d.addr.pc = {`PCSEQ_PAGE_ZERO, INSTR_OPERAND[`PCSEQ_CALL_MSB:0]};
              end
              pcseq_pkg::OP_CALL_INDIRECT: begin
                lk.push = 1'b1;
                lk.push_data = incr;
                d.addr = ptr;
              end
              pcseq_pkg::OP_TABLE_READ: begin
                // Two cycles: fetch the constant, then resume after it
                d.ret = incr;
                d.addr = ptr;
                d.state = pcseq_pkg::ST_TABLE;
              end
              pcseq_pkg::OP_SYSTEM_ENTRY: begin
                lk.push = 1'b1;
                lk.push_data = incr;
                d.addr.segment_bit = `PCSEQ_SEG_SYSTEM;
                d.addr.pc = {`PCSEQ_PAGE_ZERO,
                             INSTR_OPERAND[`PCSEQ_ENTRY_HI_MSB:`PCSEQ_ENTRY_HI_LSB],
                             `PCSEQ_BLOCK_PAD,
                             INSTR_OPERAND[`PCSEQ_ENTRY_LO_MSB:0]};
              end
              pcseq_pkg::OP_EXIT, pcseq_pkg::OP_INT_EXIT: begin
                lk.pop = 1'b1;
                d.addr = lk.top_data;
              end
              pcseq_pkg::OP_EXIT_SKIP: begin
                lk.pop = 1'b1;
                d.addr.segment_bit = lk.top_data.segment_bit;
                d.addr.pc = lk.top_data.pc + `PCSEQ_PC_ONE;
              end
              default: begin
                d.addr = incr;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bit 13 is the segment, so segment 1 starts at 2000H
  assign ROM_ADDR = q.addr;
  assign DATA_BUF = q.data_buffer;
  assign STACK_INDEX = lk.stack_index;
  assign IRQ_TAKEN = take_irq;
  assign BUSY = (q.state == pcseq_pkg::ST_TABLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  logic [`PCSEQ_PAGE_MSB:`PCSEQ_PAGE_LSB] page_now;
  assign page_now = ROM_ADDR[`PCSEQ_PAGE_MSB:`PCSEQ_PAGE_LSB];

  incr_keep_a: assert property (
    exec && op == pcseq_pkg::OP_OTHER |=>
      ROM_ADDR[`PCSEQ_PC_W-1:0] == 13'($past(ROM_ADDR[`PCSEQ_PC_W-1:0]) + `PCSEQ_PC_ONE)
      && $stable(ROM_ADDR[`PCSEQ_PC_W])
  ) else $error("increment lost or segment moved");

  wrap_same_a: assert property (
    exec && op == pcseq_pkg::OP_OTHER && ROM_ADDR[`PCSEQ_PC_W-1:0] == `PCSEQ_PC_LAST |=>
      ROM_ADDR[`PCSEQ_PC_W-1:0] == `PCSEQ_PC_RST && $stable(ROM_ADDR[`PCSEQ_PC_W])
  ) else $error("counter carried into the segment");

  jump_direct_a: assert property (
    exec && op == pcseq_pkg::OP_JUMP_DIRECT |=>
      ROM_ADDR[`PCSEQ_PC_W-1:0] == $past(INSTR_OPERAND) && $stable(ROM_ADDR[`PCSEQ_PC_W])
  ) else $error("direct jump target or segment wrong");

  jump_pointer_a: assert property (
    exec && op == pcseq_pkg::OP_JUMP_INDIRECT |=> ROM_ADDR == $past(ADDR_PTR)
  ) else $error("indirect jump not from pointer");

  call_pointer_a: assert property (
    exec && op == pcseq_pkg::OP_CALL_INDIRECT |=>
      ROM_ADDR == $past(ADDR_PTR) && STACK_INDEX == 4'($past(STACK_INDEX) - `PCSEQ_IDX_ONE)
  ) else $error("indirect call address or index wrong");

  call_page0_a: assert property (
    exec && op == pcseq_pkg::OP_CALL_DIRECT |=>
      page_now == `PCSEQ_PAGE_ZERO && $stable(ROM_ADDR[`PCSEQ_PC_W])
      && ROM_ADDR[`PCSEQ_CALL_MSB:0] == $past(INSTR_OPERAND[`PCSEQ_CALL_MSB:0])
  ) else $error("direct call left page 0");

  table_fetch_a: assert property (
    exec && op == pcseq_pkg::OP_TABLE_READ ##1 !SYS_RESET |->
      BUSY && ROM_ADDR == $past(ADDR_PTR) ##1
      !BUSY && DATA_BUF == $past(ROM_DATA)
      && ROM_ADDR[`PCSEQ_PC_W-1:0] == 13'($past(ROM_ADDR[`PCSEQ_PC_W-1:0], 2) + `PCSEQ_PC_ONE)
  ) else $error("table read sequence broken");

  system_entry_a: assert property (
    exec && op == pcseq_pkg::OP_SYSTEM_ENTRY |=>
      ROM_ADDR == {`PCSEQ_SEG_SYSTEM, `PCSEQ_PAGE_ZERO,
                   $past(INSTR_OPERAND[`PCSEQ_ENTRY_HI_MSB:`PCSEQ_ENTRY_HI_LSB]),
                   `PCSEQ_BLOCK_PAD, $past(INSTR_OPERAND[`PCSEQ_ENTRY_LO_MSB:0])}
  ) else $error("system entry address wrong");

  segment_source_a: assert property (
    $rose(ROM_ADDR[`PCSEQ_PC_W]) |->
      $past(exec && (op == pcseq_pkg::OP_SYSTEM_ENTRY || op == pcseq_pkg::OP_JUMP_INDIRECT
            || op == pcseq_pkg::OP_CALL_INDIRECT || op == pcseq_pkg::OP_TABLE_READ
            || op == pcseq_pkg::OP_EXIT || op == pcseq_pkg::OP_EXIT_SKIP
            || op == pcseq_pkg::OP_INT_EXIT)) || $past(BUSY)
  ) else $error("segment set by an unexpected instruction");

  return_slot_a: assert property (
    exec && op == pcseq_pkg::OP_EXIT |=>
      ROM_ADDR == $past(lk.top_data) && STACK_INDEX == 4'($past(STACK_INDEX) + `PCSEQ_IDX_ONE)
  ) else $error("return did not restore the slot");

  entry_round_a: assert property (
    exec && op == pcseq_pkg::OP_SYSTEM_ENTRY && STACK_INDEX != 4'h0 |=>
      lk.top_data == $past(incr)
  ) else $error("system entry slot content wrong");

  irq_vector_a: assert property (
    take_irq |=> ROM_ADDR[`PCSEQ_PC_W] == `PCSEQ_SEG_USER
      && ROM_ADDR[`PCSEQ_PC_W-1:4] == '0
      && STACK_INDEX == 4'($past(STACK_INDEX) - `PCSEQ_IDX_ONE)
  ) else $error("interrupt entry wrong");

  ce_first_a: assert property (
    take_irq && IRQ_PENDING[0] |=> ROM_ADDR == 14'h000c
  ) else $error("chip-enable vector not first");

  serial_last_a: assert property (
    take_irq && IRQ_PENDING == 12'h800 |=> ROM_ADDR == 14'h0001
  ) else $error("lowest order vector wrong");

  sync_reset_a: assert property (
    SYS_RESET |=> ROM_ADDR == '0 && !BUSY && STACK_INDEX == `PCSEQ_IDX_RST
  ) else $error("reset did not clear the address");

  // ----------------------------------------------------------------
  // Reference order for vectors
  // ----------------------------------------------------------------
  // Upward scan, first hit kept, independent of the vector module's scan
  logic [3:0] vec_ref;
  always_comb begin
    vec_ref = 4'h0;
    for (int k = 0; k < `PCSEQ_IRQ_N; k++) begin
      if (IRQ_PENDING[k] && vec_ref == 4'h0) begin
        vec_ref = 4'(`PCSEQ_IRQ_N - k);
      end
    end
  end

  irq_order_a: assert property (
    take_irq |=> ROM_ADDR == {`PCSEQ_SEG_USER, 9'h000, $past(vec_ref)}
  ) else $error("interrupt vector out of order");

  irq_gate_a: assert property (
    IRQ_TAKEN == (IRQ_ACCEPT && IRQ_PENDING != '0 && !BUSY && !SYS_RESET)
  ) else $error("interrupt acceptance gate wrong");

  irq_return_a: assert property (
    take_irq && STACK_INDEX != 4'h0 |=> lk.top_data == $past(ROM_ADDR)
  ) else $error("interrupt return address wrong");

  call_return_a: assert property (
    exec && op == pcseq_pkg::OP_CALL_DIRECT && STACK_INDEX != 4'h0 |=>
      lk.top_data == {$past(ROM_ADDR[`PCSEQ_PC_W]),
                      13'($past(ROM_ADDR[`PCSEQ_PC_W-1:0]) + `PCSEQ_PC_ONE)}
  ) else $error("direct call return address wrong");

  stack_wrap_a: assert property (
    exec && op == pcseq_pkg::OP_CALL_DIRECT && STACK_INDEX == 4'h0 |=>
      STACK_INDEX == `PCSEQ_IDX_RST && lk.top_data == '0
  ) else $error("stack overflow not wrapped");

  exit_skip_a: assert property (
    exec && op == pcseq_pkg::OP_EXIT_SKIP |=>
      ROM_ADDR[`PCSEQ_PC_W-1:0] == 13'($past(lk.top_data.pc) + `PCSEQ_PC_ONE)
      && ROM_ADDR[`PCSEQ_PC_W] == $past(lk.top_data.segment_bit)
      && STACK_INDEX == 4'($past(STACK_INDEX) + `PCSEQ_IDX_ONE)
  ) else $error("skipping return target wrong");

  int_return_a: assert property (
    exec && op == pcseq_pkg::OP_INT_EXIT |=>
      ROM_ADDR == $past(lk.top_data) && STACK_INDEX == 4'($past(STACK_INDEX) + `PCSEQ_IDX_ONE)
  ) else $error("interrupt return did not restore the slot");

  busy_hold_a: assert property (
    BUSY && !SYS_RESET |-> !IRQ_TAKEN ##1 $stable(STACK_INDEX) && !BUSY
  ) else $error("request taken during table read");

  spare_incr_a: assert property (
    exec && INSTR_OP > 4'h9 |=>
      ROM_ADDR[`PCSEQ_PC_W-1:0] == 13'($past(ROM_ADDR[`PCSEQ_PC_W-1:0]) + `PCSEQ_PC_ONE)
      && $stable(ROM_ADDR[`PCSEQ_PC_W])
  ) else $error("spare code did not increment");

  reset_keeps_a: assert property (
    SYS_RESET |=> $stable(DATA_BUF)
  ) else $error("data buffer lost on reset");

  table_seen_c: cover property (exec && op == pcseq_pkg::OP_TABLE_READ ##2 !BUSY);
  entry_exit_c: cover property (
    exec && op == pcseq_pkg::OP_SYSTEM_ENTRY ##1 exec && op == pcseq_pkg::OP_EXIT);
  irq_back_c: cover property (take_irq ##[1:8] exec && op == pcseq_pkg::OP_INT_EXIT);
  skip_exit_c: cover property (exec && op == pcseq_pkg::OP_EXIT_SKIP);
  overflow_c: cover property (exec && op == pcseq_pkg::OP_CALL_DIRECT && STACK_INDEX == 4'h0);
endmodule

// *** verilog/pcseq_consts.svh ***
`ifndef PCSEQ_CONSTS_SVH
`define PCSEQ_CONSTS_SVH

// ----------------------------------------------------------------
// Address geometry
// ----------------------------------------------------------------
`define PCSEQ_PC_W 13
`define PCSEQ_ADDR_W 14
`define PCSEQ_WORD_W 16
`define PCSEQ_PAGE_MSB 12
`define PCSEQ_PAGE_LSB 11
`define PCSEQ_CALL_MSB 10
`define PCSEQ_ENTRY_HI_MSB 6
`define PCSEQ_ENTRY_HI_LSB 4
`define PCSEQ_ENTRY_LO_MSB 3
`define PCSEQ_SEG_SYSTEM 1'b1
`define PCSEQ_SEG_USER 1'b0
`define PCSEQ_PAGE_ZERO 2'b00
`define PCSEQ_BLOCK_PAD 4'h0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PCSEQ_PC_RST 13'h0000
`define PCSEQ_PC_ONE 13'h0001
`define PCSEQ_PC_LAST 13'h1fff
`define PCSEQ_IDX_RST 4'hf
`define PCSEQ_IDX_ONE 4'h1
`define PCSEQ_STACK_DEPTH 15

// ----------------------------------------------------------------
// Interrupt vectors
// ----------------------------------------------------------------
`define PCSEQ_IRQ_N 12
`define PCSEQ_VEC_TOP 4'hc

`endif

// *** verilog/pcseq_pkg.sv ***
`include "pcseq_consts.svh"

package pcseq_pkg;
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_JUMP_DIRECT,
    OP_JUMP_INDIRECT,
    OP_CALL_DIRECT,
    OP_CALL_INDIRECT,
    OP_TABLE_READ,
    OP_SYSTEM_ENTRY,
    OP_EXIT,
    OP_EXIT_SKIP,
    OP_INT_EXIT
  } pcseq_op_e;

  typedef enum logic {
    ST_RUN,
    ST_TABLE
  } pcseq_state_e;

  typedef logic [`PCSEQ_PC_W-1:0] pcseq_pc_t;

  typedef struct packed {
    logic segment_bit;
    pcseq_pc_t pc;
  } pcseq_addr_s;
endpackage

// *** verilog/pcseq_link_if.sv ***
`include "pcseq_consts.svh"

interface pcseq_link_if;
  logic push;
  logic pop;
  logic clear;
  pcseq_pkg::pcseq_addr_s push_data;
  pcseq_pkg::pcseq_addr_s top_data;
  logic [3:0] stack_index;
  logic [`PCSEQ_IRQ_N-1:0] irq_pending;
  logic irq_any;
  logic [3:0] vector;

  modport seq (
    output push,
    output pop,
    output clear,
    output push_data,
    output irq_pending,
    input top_data,
    input stack_index,
    input irq_any,
    input vector
  );
  modport stk (
    input push,
    input pop,
    input clear,
    input push_data,
    output top_data,
    output stack_index
  );
  modport vec (
    input irq_pending,
    output irq_any,
    output vector
  );
endinterface

// *** verilog/pcseq_vec.sv ***
`include "pcseq_consts.svh"

module pcseq_vec (
  pcseq_link_if.vec lk
);
  // Downward scan: the lowest set index is seen last and wins
  always_comb begin
    lk.irq_any = 1'b0;
    lk.vector = 4'h0;
    for (int i = `PCSEQ_IRQ_N - 1; i >= 0; i--) begin
      if (lk.irq_pending[i]) begin
        lk.irq_any = 1'b1;
        lk.vector = 4'(int'(`PCSEQ_VEC_TOP) - i);
      end
    end
  end
endmodule

// *** verilog/pcseq_stack.sv ***
`include "pcseq_consts.svh"

module pcseq_stack #(
  parameter int DEPTH = `PCSEQ_STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  pcseq_link_if.stk lk
);
  typedef struct packed {
    logic [3:0] idx;
    pcseq_pkg::pcseq_addr_s [DEPTH-1:0] slot;
  } pcseq_stk_s;

  pcseq_stk_s q, d;

  // Index 15 has no slot behind it and reads as zero
  assign lk.top_data = (32'(q.idx) < DEPTH) ? q.slot[q.idx] : '0;
  assign lk.stack_index = q.idx;

  always_comb begin
    d = q;
    if (lk.clear) begin
      d.idx = `PCSEQ_IDX_RST;
    end else if (lk.push) begin
      d.idx = q.idx - `PCSEQ_IDX_ONE;
      if (32'(d.idx) < DEPTH) begin
        d.slot[d.idx] = lk.push_data;
      end
    end else if (lk.pop) begin
      d.idx = q.idx + `PCSEQ_IDX_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{idx: `PCSEQ_IDX_RST, slot: '0};
    end else begin
      q <= d;
    end
  end
endmodule

// *** dv/pcseq_rom_model.sv ***
`include "pcseq_consts.svh"

// ----------------------------------------------------------------
// Program store seen by the sequencer
// ----------------------------------------------------------------
module pcseq_rom_model (
  input wire logic [`PCSEQ_ADDR_W-1:0] addr,
  output logic [`PCSEQ_WORD_W-1:0] data
);
  // Pattern differs at every address, so a wrong fetch shows up
  assign data = {2'b10, addr} ^ 16'h5a5a;
endmodule

// *** dv/pcseq_top_tb_top.sv ***
`include "pcseq_consts.svh"

module pcseq_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic sys_reset;
  logic instr_valid;
  logic [3:0] instr_op;
  logic [`PCSEQ_PC_W-1:0] instr_operand;
  logic [`PCSEQ_ADDR_W-1:0] addr_ptr;
  logic [`PCSEQ_WORD_W-1:0] rom_data;
  logic irq_accept;
  logic [`PCSEQ_IRQ_N-1:0] irq_pending;
  logic [`PCSEQ_ADDR_W-1:0] rom_addr;
  logic [`PCSEQ_WORD_W-1:0] data_buf;
  logic [3:0] stack_index;
  logic irq_taken;
  logic busy;
  int bad_count;
  int compares;
  logic [3:0] exp_idx;

  pcseq_top dut (.CLK(clk), .RST_N(rst_n), .SYS_RESET(sys_reset), .INSTR_VALID(instr_valid),
    .INSTR_OP(instr_op), .INSTR_OPERAND(instr_operand), .ADDR_PTR(addr_ptr),
    .ROM_DATA(rom_data), .IRQ_ACCEPT(irq_accept), .IRQ_PENDING(irq_pending),
    .ROM_ADDR(rom_addr), .DATA_BUF(data_buf), .STACK_INDEX(stack_index),
    .IRQ_TAKEN(irq_taken), .BUSY(busy));

  pcseq_rom_model rom (.addr(rom_addr), .data(rom_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rom_word(input logic [13:0] a);
    return {2'b10, a} ^ 16'h5a5a;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One instruction, then an idle edge before the next one
  task automatic issue(input logic [3:0] op, input logic [12:0] opr, input logic [13:0] ptr);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_operand <= opr;
    addr_ptr <= ptr;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic push_chk(input logic [15:0] exp);
    chk(rom_addr, exp);
    exp_idx = exp_idx - 4'h1;
    chk(stack_index, exp_idx);
  endtask

  task automatic pop_chk(input logic [15:0] exp);
    chk(rom_addr, exp);
    exp_idx = exp_idx + 4'h1;
    chk(stack_index, exp_idx);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    chk(rom_addr, 16'h0000);
    chk(stack_index, 16'h000f);
    chk(data_buf, 16'h0000);
    chk(busy, 16'h0000);
  endtask

  task automatic t_wrap();
    issue(pcseq_pkg::OP_JUMP_INDIRECT, 13'h0000, 14'h1fff);
    chk(rom_addr, 16'h1fff);
    issue(pcseq_pkg::OP_OTHER, 13'h0000, 14'h0000);
    chk(rom_addr, 16'h0000);
    issue(pcseq_pkg::OP_JUMP_INDIRECT, 13'h0000, 14'h3fff);
    chk(rom_addr, 16'h3fff);
    issue(4'hf, 13'h0000, 14'h0000);
    chk(rom_addr, 16'h2000);
  endtask

  task automatic t_direct();
    issue(pcseq_pkg::OP_JUMP_DIRECT, 13'h1abc, 14'h0000);
    chk(rom_addr, 16'h3abc);
    issue(pcseq_pkg::OP_JUMP_DIRECT, 13'h0800, 14'h0000);
    chk(rom_addr, 16'h2800);
    issue(pcseq_pkg::OP_CALL_DIRECT, 13'h1fff, 14'h0000);
    push_chk(16'h27ff);
    issue(pcseq_pkg::OP_EXIT, 13'h0000, 14'h0000);
    pop_chk(16'h2801);
  endtask

  task automatic t_sys_entry();
    issue(pcseq_pkg::OP_JUMP_INDIRECT, 13'h0000, 14'h0100);
    issue(pcseq_pkg::OP_SYSTEM_ENTRY, 13'h1fa5, 14'h0000);
    push_chk(16'h2205);
    issue(pcseq_pkg::OP_SYSTEM_ENTRY, 13'h007f, 14'h0000);
    push_chk(16'h270f);
    issue(pcseq_pkg::OP_EXIT, 13'h0000, 14'h0000);
    pop_chk(16'h2206);
    issue(pcseq_pkg::OP_EXIT_SKIP, 13'h0000, 14'h0000);
    pop_chk(16'h0102);
    issue(pcseq_pkg::OP_CALL_INDIRECT, 13'h0000, 14'h3123);
    push_chk(16'h3123);
    issue(pcseq_pkg::OP_INT_EXIT, 13'h0000, 14'h0000);
    pop_chk(16'h0103);
  endtask

  // Instruction offered in the busy cycle must be dropped
  task automatic t_table();
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= pcseq_pkg::OP_TABLE_READ;
    addr_ptr <= 14'h2345;
    @(posedge clk);
    instr_op <= pcseq_pkg::OP_JUMP_DIRECT;
    instr_operand <= 13'h0055;
    #1;
    chk(busy, 16'h0001);
    chk(rom_addr, 16'h2345);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk(data_buf, rom_word(14'h2345));
    chk(rom_addr, 16'h0104);
    chk(busy, 16'h0000);
    chk(stack_index, exp_idx);
  endtask

  task automatic t_irq();
    @(posedge clk);
    irq_accept <= 1'b1;
    irq_pending <= 12'h000;
    #1;
    chk(irq_taken, 16'h0000);
    @(posedge clk);
    irq_accept <= 1'b0;
    #1;
    chk(rom_addr, 16'h0104);
    for (int i = 0; i < 12; i++) begin
      issue(pcseq_pkg::OP_JUMP_INDIRECT, 13'h0000, 14'h2800);
      @(posedge clk);
      irq_accept <= 1'b1;
      irq_pending <= 12'hfff << i;
      instr_valid <= 1'b1;
      instr_op <= pcseq_pkg::OP_JUMP_DIRECT;
      instr_operand <= 13'h0fff;
      #1;
      chk(irq_taken, 16'h0001);
      @(posedge clk);
      irq_accept <= 1'b0;
      instr_valid <= 1'b0;
      #1;
      push_chk(16'(12 - i));
      issue(pcseq_pkg::OP_INT_EXIT, 13'h0000, 14'h0000);
      pop_chk(16'h2800);
    end
  endtask

  // Data buffer survives the synchronous reset, not the power-on one
  task automatic t_resets();
    issue(pcseq_pkg::OP_CALL_DIRECT, 13'h0123, 14'h0000);
    push_chk(16'h2123);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    #1;
    chk(rom_addr, 16'h0000);
    chk(stack_index, 16'h000f);
    chk(data_buf, rom_word(14'h2345));
    exp_idx = 4'hf;
    issue(pcseq_pkg::OP_JUMP_INDIRECT, 13'h0000, 14'h3123);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk(rom_addr, 16'h0000);
    chk(data_buf, 16'h0000);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Sixteenth call lands on the slotless index and wraps it
  task automatic t_overflow();
    for (int n = 0; n < 16; n++) begin
      issue(pcseq_pkg::OP_CALL_DIRECT, 13'h0010, 14'h0000);
      push_chk(16'h0010);
    end
    issue(pcseq_pkg::OP_EXIT, 13'h0000, 14'h0000);
    pop_chk(16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    bad_count = 0;
    compares = 0;
    exp_idx = 4'hf;
    rst_n = 1'b0;
    sys_reset = 1'b0;
    instr_valid = 1'b0;
    instr_op = 4'h0;
    instr_operand = 13'h0000;
    addr_ptr = 14'h0000;
    irq_accept = 1'b0;
    irq_pending = 12'h000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset_values();
    t_wrap();
    t_direct();
    t_sys_entry();
    t_table();
    t_irq();
    t_resets();
    #1;
    t_reset_values();
    t_overflow();
    complete_run();
  end
endmodule
